// File: rtl/dpc_controller.sv
/*
 * Custom memory controller, PHY side duties: issues one control word
 * per fabric cycle with matching command pins, termination per rank,
 * temperature sample enable, idle indication and sensor hand-off.
 * Assumes an AHB-Lite master with single word transfers and a PHY
 * that pulls one command per control word.
 */
module dpc_controller #(
    parameter int ADDR_W = 14,
    parameter int BANK_W = 3
) (
    // AHB-Lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // PHY control word and command pins
    output logic [31:0] phy_control_word,
    output logic phy_ctl_wren,
    output logic phy_cmd_wren,
    output logic [ADDR_W-1:0] mc_address,
    output logic [BANK_W-1:0] mc_bank,
    output logic mc_cs_n,
    output logic mc_ras_n,
    output logic mc_cas_n,
    output logic mc_we_n,
    output logic [3:0] mc_burst_len,
    output logic [7:0] mc_wr_mask_beats,
    // Termination, idle, temperature
    output logic [1:0] rank_term_request,
    output logic idle,
    output logic tempmon_sample_en,
    output logic [11:0] device_temp,
    output logic data_io_pwrdn_on,
    // PHY status, other clock domains
    input wire logic calib_done,
    input wire logic rd_data_valid
);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] ctrl;
    logic [31:0] cmd_reg;
    logic cmd_pending;
    logic take_cmd;
    logic [11:0] temp_reg;
    logic [31:0] issued;
    logic [1:0] calib_sync;
    logic [1:0] rdv_sync;
    logic busy;
    logic [1:0] term_int;
    logic [1:0] write_now;

    wire addr_phase = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= addr_phase & hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // Latched in the address phase, stands until the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            unique case (haddr[7:0])
                dpc_pkg::CTRL_ADDR: hrdata <= ctrl;
                dpc_pkg::CMD_ADDR: hrdata <= cmd_reg;
                dpc_pkg::STATUS_ADDR: hrdata <= {23'h000000, cmd_pending, 2'h0,
                                                 rank_term_request, 1'b0,
                                                 tempmon_sample_en, idle, busy};
                dpc_pkg::TEMP_ADDR: hrdata <= {20'h00000, temp_reg};
                dpc_pkg::COUNT_ADDR: hrdata <= issued;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Both registers take their data in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= dpc_pkg::CTRL_RESET;
            temp_reg <= 12'h000;
        end else if (wr_pend && wr_addr == dpc_pkg::CTRL_ADDR) begin
            ctrl <= hwdata;
        end else if (wr_pend && wr_addr == dpc_pkg::TEMP_ADDR) begin
            temp_reg <= hwdata[11:0];
        end
    end

    // Command mailbox; a new command while one waits is dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_reg <= 32'h0000_0000;
            cmd_pending <= 1'b0;
        end else if (wr_pend && wr_addr == dpc_pkg::CMD_ADDR && !cmd_pending) begin
            cmd_reg <= hwdata;
            cmd_pending <= 1'b1;
        end else if (take_cmd) begin
            cmd_pending <= 1'b0;
        end
    end

    // Raw sensor value passed through untouched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            device_temp <= 12'h000;
            data_io_pwrdn_on <= 1'b0;
        end else begin
            device_temp <= temp_reg;
            data_io_pwrdn_on <= ctrl[dpc_pkg::CTRL_PWRDN_BIT];
        end
    end

    // ------------------------------------------------------------
    // Synchronisers for PHY status
    // ------------------------------------------------------------
    // Both come from the PHY's own clocks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            calib_sync <= 2'b00;
            rdv_sync <= 2'b00;
        end else begin
            calib_sync <= {calib_sync[0], calib_done};
            rdv_sync <= {rdv_sync[0], rd_data_valid};
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DPC_IDLE,
        DPC_READ_DRAIN,
        DPC_WAIT_CLEAR,
        DPC_MAINT,
        DPC_SAMPLE_GAP
    } dpc_state_t;

    dpc_state_t state;
    // Counts down drain and maintenance spans
    logic [15:0] timer;
    logic is_ref;
    logic [2:0] kind;
    logic rank;
    logic [1:0] slot;

    assign kind = cmd_reg[dpc_pkg::CMD_KIND_LSB +: 3];
    assign rank = cmd_reg[dpc_pkg::CMD_RANK_BIT];
    assign slot = cmd_reg[dpc_pkg::CMD_SLOT_LSB +: 2];
    // Nothing issues before calibration is seen settled
    assign take_cmd = cmd_pending && state == DPC_IDLE && ctrl[dpc_pkg::CTRL_ENABLE_BIT]
                      && calib_sync[1];
    assign busy = state != DPC_IDLE;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= DPC_IDLE;
            timer <= 16'h0000;
            is_ref <= 1'b0;
        end else begin
            unique case (state)
                DPC_IDLE: begin
                    if (take_cmd) begin
                        if (kind == dpc_pkg::DPC_KIND_READ) begin
                            state <= DPC_READ_DRAIN;
                            timer <= 16'(dpc_pkg::RD_DRAIN_CYC);
                        end else if (kind == dpc_pkg::DPC_KIND_REFRESH ||
                                     kind == dpc_pkg::DPC_KIND_ZQS) begin
                            // Wait for data bus to drain before sampling
                            state <= DPC_WAIT_CLEAR;
                            timer <= 16'(dpc_pkg::RD_DRAIN_CYC);
                            is_ref <= kind == dpc_pkg::DPC_KIND_REFRESH;
                        end
                    end
                end
                // Fixed wait first, then until read-valid has gone
                DPC_READ_DRAIN: begin
                    timer <= timer - 16'h0001;
                    if (timer == 16'h0001 && !rdv_sync[1]) begin
                        state <= DPC_IDLE;
                    end else if (timer == 16'h0001) begin
                        timer <= 16'h0001;
                    end
                end
                DPC_WAIT_CLEAR: begin
                    timer <= timer - 16'h0001;
                    if (timer == 16'h0001) begin
                        state <= DPC_MAINT;
                        timer <= is_ref ? 16'(dpc_pkg::TRFC_CYC) : 16'(dpc_pkg::TZQCS_CYC);
                    end
                end
                DPC_MAINT: begin
                    timer <= timer - 16'h0001;
                    if (timer == 16'h0001) begin
                        state <= DPC_SAMPLE_GAP;
                    end
                end
                DPC_SAMPLE_GAP: state <= DPC_IDLE;
                default: state <= DPC_IDLE;
            endcase
        end
    end

    // Sample enable spans the whole maintenance command, low before next
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tempmon_sample_en <= 1'b0;
        end else begin
            tempmon_sample_en <= (state == DPC_WAIT_CLEAR && timer == 16'h0001) ||
                                 (state == DPC_MAINT && timer != 16'h0001);
        end
    end

    // Idle drops the cycle after a read is taken, returns when drained
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle <= 1'b1;
        end else if (take_cmd && kind == dpc_pkg::DPC_KIND_READ) begin
            idle <= 1'b0;
        end else if (state == DPC_IDLE && !cmd_pending) begin
            idle <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Control word stream, one per cycle
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phy_control_word <= 32'h0000_0000;
            phy_ctl_wren <= 1'b0;
            phy_cmd_wren <= 1'b0;
            {mc_cs_n, mc_ras_n, mc_cas_n, mc_we_n} <= dpc_pkg::PIN_NOP;
            mc_address <= '0;
            mc_bank <= '0;
            mc_burst_len <= dpc_pkg::BURST_LEN;
            mc_wr_mask_beats <= 8'h00;
            issued <= 32'h0000_0000;
        end else begin
            // Word and command always written together so queues stay paired
            phy_ctl_wren <= ctrl[dpc_pkg::CTRL_ENABLE_BIT];
            phy_cmd_wren <= ctrl[dpc_pkg::CTRL_ENABLE_BIT];
            mc_burst_len <= dpc_pkg::BURST_LEN;
            mc_address <= cmd_reg[31 -: ADDR_W];
            mc_bank <= cmd_reg[12 +: BANK_W];
            phy_control_word <= {27'h0000000, slot, dpc_pkg::CW_NON_DATA};
            {mc_cs_n, mc_ras_n, mc_cas_n, mc_we_n} <= dpc_pkg::PIN_NOP;
            mc_wr_mask_beats <= 8'h00;
            if (take_cmd) begin
                issued <= issued + 32'h0000_0001;
                unique case (kind)
                    dpc_pkg::DPC_KIND_READ: begin
                        phy_control_word <= {27'h0000000, slot, dpc_pkg::CW_READ};
                        {mc_cs_n, mc_ras_n, mc_cas_n, mc_we_n} <= dpc_pkg::PIN_READ;
                    end
                    dpc_pkg::DPC_KIND_WRITE: begin
                        phy_control_word <= {27'h0000000, slot, dpc_pkg::CW_WRITE};
                        {mc_cs_n, mc_ras_n, mc_cas_n, mc_we_n} <= dpc_pkg::PIN_WRITE;
                        // Chop: still eight beats, upper four masked
                        mc_wr_mask_beats <= cmd_reg[3] ? 8'hF0 : 8'h00;
                    end
                    dpc_pkg::DPC_KIND_REFRESH:
                        {mc_cs_n, mc_ras_n, mc_cas_n, mc_we_n} <= dpc_pkg::PIN_REFRESH;
                    dpc_pkg::DPC_KIND_ZQS:
                        {mc_cs_n, mc_ras_n, mc_cas_n, mc_we_n} <= dpc_pkg::PIN_ZQ;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Termination per rank
    // ------------------------------------------------------------
    // Write strobe seen combinationally so termination rises with the word
    assign write_now = (take_cmd && kind == dpc_pkg::DPC_KIND_WRITE) ?
                       (rank ? 2'b10 : 2'b01) : 2'b00;

    dpc_term_gen #(
        .RANKS(dpc_pkg::RANKS)
    ) u_term (
        .hclk(hclk),
        .hresetn(hresetn),
        .write_now(write_now),
        .rank_term_request(term_int)
    );

    // Registered so it aligns with the write word; no CWL alignment needed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rank_term_request <= 2'b00;
        end else begin
            rank_term_request <= term_int;
        end
    end

endmodule : dpc_controller

// File: shared/dpc_pkg.sv
/*
 * Constants for the custom memory controller that drives the PHY:
 * register map, control word encodings, command pin patterns.
 * Assumes a 50 MHz fabric clock and a 4:1 PHY with four command slots.
 */
package dpc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] CMD_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [7:0] TEMP_ADDR = 8'h0C;
    localparam logic [7:0] COUNT_ADDR = 8'h10;

    // CTRL fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_PWRDN_BIT = 1;
    // CMD fields: kind, rank, slot
    localparam int CMD_KIND_LSB = 0;
    localparam int CMD_RANK_BIT = 4;
    localparam int CMD_SLOT_LSB = 8;
    // STATUS fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_IDLE_BIT = 1;
    localparam int ST_SAMPLE_BIT = 2;
    localparam int ST_TERM_LSB = 4;
    localparam int ST_PEND_BIT = 8;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Command kinds that software may queue
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DPC_KIND_READ = 3'h1,
        DPC_KIND_WRITE = 3'h2,
        DPC_KIND_REFRESH = 3'h3,
        DPC_KIND_ZQS = 3'h4
    } dpc_kind_t;

    // ------------------------------------------------------------
    // Control word low bits and burst
    // ------------------------------------------------------------
    localparam logic [2:0] CW_WRITE = 3'h1;
    localparam logic [2:0] CW_READ = 3'h3;
    localparam logic [2:0] CW_NON_DATA = 3'h4;
    localparam logic [3:0] BURST_LEN = 4'h8;
    localparam int SLOTS = 4;
    localparam int RANKS = 2;

    // Pin patterns {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] PIN_NOP = 4'h7;
    localparam logic [3:0] PIN_READ = 4'h5;
    localparam logic [3:0] PIN_WRITE = 4'h4;
    localparam logic [3:0] PIN_REFRESH = 4'h1;
    localparam logic [3:0] PIN_ZQ = 4'h6;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int TRFC_NS = 160;
    localparam int TRFC_CYC = (TRFC_NS * CLK_MHZ + 999) / 1000;
    localparam int TZQCS_NS = 80;
    localparam int TZQCS_CYC = (TZQCS_NS * CLK_MHZ + 999) / 1000;
    localparam int RD_DRAIN_NS = 200;
    localparam int RD_DRAIN_CYC = (RD_DRAIN_NS * CLK_MHZ + 999) / 1000;

endpackage : dpc_pkg

// File: rtl/dpc_term_gen.sv
/*
 * Per-rank termination request generator.
 * Assumes write strobes arrive one cycle per control word on hclk.
 */
module dpc_term_gen #(
    parameter int RANKS = 2
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Write in this cycle, per rank
    input wire logic [RANKS-1:0] write_now,
    // Request out
    output logic [RANKS-1:0] rank_term_request
);

    logic [RANKS-1:0] write_prev;

    genvar r;
    generate
        for (r = 0; r < RANKS; r++) begin : g_rank
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    write_prev[r] <= 1'b0;
                end else begin
                    write_prev[r] <= write_now[r];
                end
            end
            // Held with the write and one cycle after; idle ranks stay low
            assign rank_term_request[r] = write_now[r] | write_prev[r];
        end
    endgenerate

endmodule : dpc_term_gen

// File: dv/dpc_ctrl_props.sv
/* Assertions on the PHY-side ports of dpc_controller.
   Bound from the bench top; one clock, active-low reset. */
module dpc_ctrl_props (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // PHY side
    input wire logic [31:0] phy_control_word,
    input wire logic phy_ctl_wren,
    input wire logic phy_cmd_wren,
    input wire logic mc_cs_n,
    input wire logic mc_ras_n,
    input wire logic mc_cas_n,
    input wire logic mc_we_n,
    input wire logic [3:0] mc_burst_len,
    input wire logic [7:0] mc_wr_mask_beats,
    input wire logic [1:0] rank_term_request,
    input wire logic idle,
    input wire logic tempmon_sample_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_w;
    logic [3:0] pins;
    int scnt;
    assign wr_w = phy_ctl_wren && phy_control_word[2:0] == dpc_pkg::CW_WRITE;
    assign pins = {mc_cs_n, mc_ras_n, mc_cas_n, mc_we_n};
    // Length of the current sample window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) scnt <= 0;
        else scnt <= tempmon_sample_en ? scnt + 1 : 0;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    burst_eight_a: assert property (mc_burst_len == dpc_pkg::BURST_LEN)
        else $error("burst length not eight");
    chop_mask_a: assert property (mc_wr_mask_beats != 8'h00 |->
        wr_w && mc_wr_mask_beats == 8'hF0) else $error("mask outside a chopped write");
    term_two_a: assert property (wr_w |-> $onehot(rank_term_request) ##1
        rank_term_request == $past(rank_term_request)) else $error("write term not two cycles");
    term_pins_a: assert property (pins == dpc_pkg::PIN_WRITE |-> rank_term_request != 2'b00)
        else $error("write pins without term");
    term_drop_a: assert property (wr_w ##1 !wr_w |=> rank_term_request == 2'b00)
        else $error("term longer than one extra cycle");
    term_cause_a: assert property (rank_term_request != 2'b00 |-> wr_w || $past(wr_w))
        else $error("term without a write");
    wren_pair_a: assert property (phy_ctl_wren == phy_cmd_wren)
        else $error("control and command enables differ");
    nop_word_a: assert property (phy_ctl_wren && pins == dpc_pkg::PIN_NOP |->
        phy_control_word[2:0] == dpc_pkg::CW_NON_DATA) else $error("nop without non-data word");
    idle_read_a: assert property ($fell(idle) |-> phy_ctl_wren &&
        phy_control_word[2:0] == dpc_pkg::CW_READ) else $error("idle fell without read");
    sample_quiet_a: assert property (tempmon_sample_en |-> idle && pins == dpc_pkg::PIN_NOP)
        else $error("sample while bus busy");
    sample_len_a: assert property (scnt <= dpc_pkg::TRFC_CYC)
        else $error("sample held too long");
    cover property (wr_w);
    cover property ($fell(idle));
    cover property ($rose(tempmon_sample_en));
endmodule : dpc_ctrl_props

// File: dv/dpc_phy_model.sv
/* Behavioural PHY facing dpc_controller: calibration, read return,
   temperature tracking, I/O power-down. Runs on hclk only. */
module dpc_phy_model #(
    parameter int CAL_CYC = 40,
    parameter logic [11:0] TEMP_STEP = 12'h020
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // From controller
    input wire logic [31:0] phy_control_word,
    input wire logic phy_ctl_wren,
    input wire logic phy_cmd_wren,
    input wire logic [3:0] mc_burst_len,
    input wire logic idle,
    input wire logic data_io_pwrdn_on,
    input wire logic tempmon_sample_en,
    input wire logic [11:0] device_temp,
    // Read return length, large means a slow PHY
    input wire logic [7:0] rd_len,
    // To controller and bench
    output logic calib_done,
    output logic rd_data_valid,
    output logic io_pwrdn,
    output logic [5:0] fine_delay,
    output logic [11:0] baseline,
    output int flow_err
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc;
    int rd_cnt;
    logic smp_d;
    assign io_pwrdn = data_io_pwrdn_on ? idle : 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc <= 0;
            calib_done <= 1'b0;
            baseline <= 12'h000;
            fine_delay <= 6'h00;
            smp_d <= 1'b0;
        end else begin
            smp_d <= tempmon_sample_en;
            if (cyc < CAL_CYC) cyc <= cyc + 1;
            else if (!calib_done) begin
                calib_done <= 1'b1;
                baseline <= device_temp;
            end else if (tempmon_sample_en && !smp_d) begin
                if (device_temp >= baseline + TEMP_STEP) begin
                    fine_delay <= fine_delay + 6'h01;
                    baseline <= device_temp;
                end else if (baseline >= device_temp + TEMP_STEP) begin
                    fine_delay <= fine_delay - 6'h01;
                    baseline <= device_temp;
                end
            end
        end
    end
    // Control queue pulls a command per word, blind to its fill
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_cnt <= 0;
            rd_data_valid <= 1'b0;
            flow_err <= 0;
        end else begin
            rd_data_valid <= rd_cnt != 0 && rd_cnt <= int'(rd_len);
            if (phy_ctl_wren && phy_control_word[2:0] == dpc_pkg::CW_READ) begin
                rd_cnt <= int'(rd_len) + 4;
            end else if (rd_cnt != 0) begin
                rd_cnt <= rd_cnt - 1;
            end
            if (phy_ctl_wren != phy_cmd_wren || (phy_ctl_wren && mc_burst_len != 4'h8)) begin
                flow_err <= flow_err + 1;
            end
        end
    end
endmodule : dpc_phy_model

// File: dv/dpc_controller_tb.sv
/* Bench for dpc_controller with the PHY model on its far side.
   AHB-Lite single word transfers; one 50 MHz clock. */
module dpc_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] rd_len = 8'h04;
    logic [31:0] hrdata, phy_control_word, rv;
    logic hready, hreadyout, hresp, phy_ctl_wren, phy_cmd_wren;
    logic mc_cs_n, mc_ras_n, mc_cas_n, mc_we_n;
    logic [3:0] mc_burst_len;
    logic [7:0] mc_wr_mask_beats;
    logic [13:0] mc_address;
    logic [2:0] mc_bank;
    logic [1:0] rank_term_request;
    logic idle, tempmon_sample_en, data_io_pwrdn_on, calib_done, rd_data_valid, io_pwrdn;
    logic [11:0] device_temp, baseline;
    logic [5:0] fine_delay;
    int flow_err;
    int n_fail = 0;
    int comparisons = 0;
    int cnt[7] = '{default: 0};
    int s[7];
    int e0;
    assign hready = hreadyout;
    dpc_controller dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .phy_control_word, .phy_ctl_wren, .phy_cmd_wren,
        .mc_address, .mc_bank, .mc_cs_n, .mc_ras_n, .mc_cas_n, .mc_we_n, .mc_burst_len,
        .mc_wr_mask_beats, .rank_term_request, .idle, .tempmon_sample_en, .device_temp,
        .data_io_pwrdn_on, .calib_done, .rd_data_valid);
    dpc_phy_model phy (.hclk, .hresetn, .phy_control_word, .phy_ctl_wren, .phy_cmd_wren,
        .mc_burst_len, .idle, .data_io_pwrdn_on, .tempmon_sample_en, .device_temp, .rd_len,
        .calib_done, .rd_data_valid, .io_pwrdn, .fine_delay, .baseline, .flow_err);
    initial forever #10 hclk = ~hclk;
    // ----------------------------------------
    // Activity counters, read as differences
    // ----------------------------------------
    always @(posedge hclk) begin
        cnt[0] <= cnt[0] + (rank_term_request[0] === 1'b1 ? 1 : 0);
        cnt[1] <= cnt[1] + (rank_term_request[1] === 1'b1 ? 1 : 0);
        cnt[2] <= cnt[2] + (tempmon_sample_en === 1'b1 ? 1 : 0);
        cnt[3] <= cnt[3] + (idle === 1'b0 ? 1 : 0);
        cnt[4] <= cnt[4] + (phy_ctl_wren && phy_control_word[2:0] === dpc_pkg::CW_WRITE ? 1 : 0);
        cnt[5] <= cnt[5] + (io_pwrdn !== idle ? 1 : 0);
        cnt[6] <= cnt[6] + (mc_wr_mask_beats === 8'hF0 ? 1 : 0);
    end
    task stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One single transfer; caller stands just after a rising edge
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        do begin @(posedge hclk); end while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge hclk); end while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    function logic [31:0] mk(input logic [2:0] k, input logic ch, input logic r,
        input logic [1:0] sl);
        mk = 32'h0;
        mk[2:0] = k;
        mk[3] = ch;
        mk[dpc_pkg::CMD_RANK_BIT] = r;
        mk[dpc_pkg::CMD_SLOT_LSB +: 2] = sl;
    endfunction : mk
    function int dl(input int k);
        return cnt[k] - s[k];
    endfunction : dl
    // Queue a command, poll until done, then let the term tail pass
    task cmd(input logic [31:0] c);
        int i;
        s = cnt;
        bus(1'b1, dpc_pkg::CMD_ADDR, c, rv);
        i = 0;
        do begin bus(1'b0, dpc_pkg::STATUS_ADDR, 32'h0, rv); i++; end
            while ((rv[dpc_pkg::ST_BUSY_BIT] || rv[dpc_pkg::ST_PEND_BIT]) && i < 200);
        if (i >= 200) n_fail++;
        repeat (4) @(posedge hclk);
    endtask : cmd
    initial begin
        int i;
        logic [5:0] f0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, dpc_pkg::CTRL_ADDR, 32'h0, rv);
        chk(rv, dpc_pkg::CTRL_RESET);
        bus(1'b0, 8'h20, 32'h0, rv);
        chk(rv, 32'h0);
        chk(hresp, 1'b0);
        bus(1'b0, dpc_pkg::STATUS_ADDR, 32'h0, rv);
        chk(rv[dpc_pkg::ST_IDLE_BIT], 1);
        bus(1'b1, dpc_pkg::TEMP_ADDR, 32'h100, rv);
        bus(1'b1, dpc_pkg::CTRL_ADDR, 32'h3, rv);
        bus(1'b0, dpc_pkg::CTRL_ADDR, 32'h0, rv);
        chk(rv, 32'h3);
        i = 0;
        while (calib_done !== 1'b1 && i < 200) begin @(posedge hclk); i++; end
        @(posedge hclk);
        chk(device_temp, 12'h100);
        chk(baseline, 12'h100);
        chk({phy_control_word[2:0], mc_cs_n, mc_ras_n, mc_cas_n, mc_we_n},
            {dpc_pkg::CW_NON_DATA, dpc_pkg::PIN_NOP});
        chk(io_pwrdn, 1);
        e0 = cnt[5];
        for (int r = 0; r < 2; r++) begin
            cmd(mk(dpc_pkg::DPC_KIND_WRITE, 1'b0, r[0], r[1:0]));
            chk(dl(r), 2);
            chk(dl(1 - r), 0);
            chk(dl(4), 1);
        end
        cmd(mk(dpc_pkg::DPC_KIND_WRITE, 1'b1, 1'b0, 2'h2) | 32'hFFFC_7000);
        chk({mc_address, mc_bank}, 17'h1FFFF);
        chk(dl(6), 1);
        chk(dl(0), 2);
        chk(mc_burst_len, dpc_pkg::BURST_LEN);
        for (int k = 0; k < 2; k++) begin
            rd_len <= k ? 8'd20 : 8'd4;
            cmd(mk(dpc_pkg::DPC_KIND_READ, 1'b0, k[0], 2'h1));
            chk(dl(3) >= int'(rd_len), 1);
            chk(dl(0) + dl(1), 0);
            chk(idle, 1);
        end
        f0 = fine_delay;
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, dpc_pkg::TEMP_ADDR, k ? 32'h140 : 32'h105, rv);
            cmd(mk(k ? dpc_pkg::DPC_KIND_ZQS : dpc_pkg::DPC_KIND_REFRESH, 1'b0, 1'b0, 2'h0));
            chk(dl(2), k ? dpc_pkg::TZQCS_CYC : dpc_pkg::TRFC_CYC);
            chk(device_temp, k ? 12'h140 : 12'h105);
            chk(fine_delay, f0 + 6'(k));
        end
        chk(baseline, 12'h140);
        bus(1'b0, dpc_pkg::COUNT_ADDR, 32'h0, rv);
        chk(rv, 32'h0000_0007);
        chk(cnt[5] - e0, 0);
        bus(1'b1, dpc_pkg::CTRL_ADDR, 32'h1, rv);
        repeat (2) @(posedge hclk);
        chk(io_pwrdn, 0);
        chk(flow_err, 0);
        stop_test();
    end
    // Whole run is a few hundred cycles
    initial begin
        #600000;
        n_fail++;
        stop_test();
    end
endmodule : dpc_controller_tb

bind dpc_controller dpc_ctrl_props u_props (.hclk, .hresetn, .phy_control_word, .phy_ctl_wren,
    .phy_cmd_wren, .mc_cs_n, .mc_ras_n, .mc_cas_n, .mc_we_n, .mc_burst_len, .mc_wr_mask_beats,
    .rank_term_request, .idle, .tempmon_sample_en);
